// file: src/mtz_consts.vh
`ifndef MTZ_CONSTS_VH
`define MTZ_CONSTS_VH
// Register byte offsets
`define MTZ_REG_CMD 8'h00
`define MTZ_REG_SETUP 8'h04
`define MTZ_REG_STATUS 8'h08
`define MTZ_REG_LFREQ 8'h0c
`define MTZ_REG_AZERO 8'h10
`define MTZ_REG_CONFIG 8'h14
`define MTZ_REG_ERROR 8'h18
// Command codes written to CMD[3:0]
`define MTZ_CMD_ARM 4'h1
`define MTZ_CMD_CANCEL 4'h2
`define MTZ_CMD_SETUP 4'h3
`define MTZ_CMD_SETUP_MEAS 4'h4
`define MTZ_CMD_SW_TRIG 4'h5
`define MTZ_CMD_BUS_TRIG 4'h6
`define MTZ_CMD_RESET 4'h7
`define MTZ_CMD_READ 4'h8
`define MTZ_CMD_LFREQ 4'h9
`define MTZ_CMD_LFREQ_Q 4'ha
`define MTZ_CMD_AZERO 4'hb
// Keyword codes in CMD[9:8]
`define MTZ_KW_VALUE 2'h0
`define MTZ_KW_MIN 2'h1
`define MTZ_KW_MAX 2'h2
// Trigger sources
`define MTZ_SRC_IMM 2'h0
`define MTZ_SRC_BUS 2'h1
`define MTZ_SRC_HOLD 2'h2
`define MTZ_SRC_EXT 2'h3
// Autozero modes
`define MTZ_AZ_OFF 2'h0
`define MTZ_AZ_ON 2'h1
`define MTZ_AZ_SINGLE_ZERO_OPTION 2'h2
// Line frequencies and timings
`define MTZ_LF_50 8'h32
`define MTZ_LF_60 8'h3c
`define MTZ_LF_RESET 8'h3c
`define MTZ_APER_60_US 16700
`define MTZ_APER_50_US 20000
`define MTZ_AC_DELAY_MS 500
`define MTZ_CLK_MHZ 100
`define MTZ_AC_DELAY_CYC (`MTZ_AC_DELAY_MS * 1000 * `MTZ_CLK_MHZ)
// Error codes
`define MTZ_ERR_NONE 8'h00
`define MTZ_ERR_TRIG_IGN 8'h01
`define MTZ_ERR_CANCEL 8'h02
`define MTZ_ERR_PARAM 8'h03
`endif

// file: src/mtz_control.v
`timescale 1ns/1ns
`include "mtz_consts.vh"
// Notes on behaviour
// - Cancel with bus-message or suspended source leaves wait-for-trigger and returns to idle; other sources record an error.
// - Cancel keeps all other trigger settings so re-arming behaves identically.
// - Bus-message source, idle after cancel: bus trigger ignored, error recorded.
// - Suspended source, idle after cancel: software trigger ignored, error recorded.
// - Instrument reset returns trigger state to idle like cancel, but for every trigger source.
// - Line frequency accepts only 50 or 60; MIN is 50, MAX is 60.
// - Line frequency defaults 60, changed only by its command, kept by reset.
// - Line query returns setting, 50 for MIN, 60 for MAX.
// - Autozero on: zero measurement follows every reading and is subtracted.
// - Autozero off or single_zero_option: one zero kept, redone on function change.
// - Range change never causes an extra zero measurement.
// - No autozero while the 10 us aperture is selected.
// - Setup commands and reset switch autozero on.
// - Autozero query gives 1 for on, else 0; 1 and 0 accepted.
// - MTZ_CMD_SETUP loads configuration only; arm, read or MTZ_CMD_SETUP_MEAS starts acquisition.
// - Setup sets requested range or autorange and one line cycle integration.
// - Setup sets trigger count and delay automatic; AC delay 0.5 s.
// - Setup selects immediate trigger, sample count 1, offset compensation off.
module mtz_control #(
    parameter AC_DELAY_CYC = `MTZ_AC_DELAY_CYC
)(
    // Clock and reset
    input wire ref_clk,
    input wire nrst,
    // AXI4-Lite write
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // AXI4-Lite read
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // Converter side
    input wire conv_done,
    output reg conv_start_q,
    output reg conv_zero_q,
    output reg conv_input_en_q,
    output reg subtract_zero_q
);

localparam ST_IDLE = 4'b0001;
localparam ST_WAIT = 4'b0010;
localparam ST_MEAS = 4'b0100;
localparam ST_ZERO = 4'b1000;
localparam [31:0] AC_DLY = AC_DELAY_CYC;

////////////////////////////////////////////////////////////////////////////////
// Register state

reg [3:0] state_q;
reg [1:0] trig_src_q;
reg [7:0] trig_count_q;
reg trig_count_auto_q;
reg trig_delay_auto_q;
reg [7:0] sample_count_q;
reg samp_src_imm_q;
reg ocomp_q;
reg [1:0] azero_q;
reg [7:0] lfreq_q;
reg [1:0] func_q;
reg [2:0] range_q;
reg autorange_q;
reg [3:0] integration_line_cycles_q;
reg aper_10us_q;
reg zero_valid_q;
reg [7:0] err_q;
reg [7:0] lf_query_q;
reg [31:0] delay_cnt_q;
reg [7:0] trig_left_q;
reg conv_busy_q;

////////////////////////////////////////////////////////////////////////////////
// AXI4-Lite slave

reg aw_full_q;
reg w_full_q;
reg [7:0] aw_q;
reg [31:0] w_q;
wire wr_go = aw_full_q && w_full_q && !s_axi_bvalid;
assign s_axi_awready = !aw_full_q;
assign s_axi_wready = !w_full_q;
assign s_axi_arready = !s_axi_rvalid;

function [3:0] reg_index;
    input [7:0] addr;
    begin
        reg_index = (addr[1:0] == 2'h0 && addr <= `MTZ_REG_ERROR) ? {1'b0, addr[4:2]} : 4'hf;
    end
endfunction

wire [3:0] wr_idx = reg_index(aw_q);
reg [3:0] w_q_strb;
wire cmd_go = wr_go && wr_idx == 4'h0 && w_q_strb[0];
wire [3:0] cmd_code = w_q[3:0];
wire [1:0] cmd_kw = w_q[9:8];
wire [7:0] cmd_arg = w_q[23:16];

// Line frequency argument decode
wire lf_ok = cmd_kw == `MTZ_KW_MIN || cmd_kw == `MTZ_KW_MAX ||
    (cmd_kw == `MTZ_KW_VALUE && (cmd_arg == `MTZ_LF_50 || cmd_arg == `MTZ_LF_60));
wire [7:0] lf_val = cmd_kw == `MTZ_KW_MIN ? `MTZ_LF_50 :
    cmd_kw == `MTZ_KW_MAX ? `MTZ_LF_60 : cmd_arg;

// Line frequency value store: starts at 60, untouched by reset commands
always @(posedge ref_clk or negedge nrst)
begin
    if (!nrst)
        lfreq_q <= `MTZ_LF_RESET;
    else if (cmd_go && cmd_code == `MTZ_CMD_LFREQ && lf_ok)
        lfreq_q <= lf_val;
end

always @(posedge ref_clk or negedge nrst)
begin
    if (!nrst)
    begin
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
        aw_q <= 8'h00;
        w_q <= 32'h0000_0000;
        w_q_strb <= 4'h0;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= 2'h0;
    end
    else
    begin
        if (s_axi_awvalid && !aw_full_q)
        begin
            aw_full_q <= 1'b1;
            aw_q <= s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_full_q)
        begin
            w_full_q <= 1'b1;
            w_q <= s_axi_wdata;
            w_q_strb <= s_axi_wstrb;
        end
        if (wr_go)
        begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (wr_idx == 4'hf) ? 2'h3 : 2'h0;
        end
        else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end
end

// Setup and config register write strobes
wire setup_wr = wr_go && wr_idx == 4'h1;
wire cfg_wr = wr_go && wr_idx == 4'h5;

always @(posedge ref_clk or negedge nrst)
begin
    if (!nrst)
    begin
        s_axi_rvalid <= 1'b0;
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= 2'h0;
    end
    else if (s_axi_arvalid && !s_axi_rvalid)
    begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'h0;
        case (reg_index(s_axi_araddr))
            4'h1: s_axi_rdata <= {21'h00000, aper_10us_q, integration_line_cycles_q, autorange_q, range_q, func_q};
            4'h2: s_axi_rdata <= {24'h000000, zero_valid_q, state_q == ST_WAIT, state_q == ST_IDLE,
                                  samp_src_imm_q, ocomp_q, trig_count_auto_q, trig_delay_auto_q, 1'b0};
            4'h3: s_axi_rdata <= {16'h0000, lf_query_q, lfreq_q};
            4'h4: s_axi_rdata <= {29'h0000000, azero_q, azero_q == `MTZ_AZ_ON};
            4'h5: s_axi_rdata <= {8'h00, sample_count_q, trig_count_q, 6'h00, trig_src_q};
            4'h6: s_axi_rdata <= {24'h000000, err_q};
            4'h0: s_axi_rdata <= 32'h0000_0000;
            default:
            begin
                s_axi_rdata <= 32'h0000_0000;
                s_axi_rresp <= 2'h3;
            end
        endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
end

////////////////////////////////////////////////////////////////////////////////
// Command interpreter

wire is_cancel = cmd_go && cmd_code == `MTZ_CMD_CANCEL;
wire is_reset = cmd_go && cmd_code == `MTZ_CMD_RESET;
wire is_setup = cmd_go && (cmd_code == `MTZ_CMD_SETUP || cmd_code == `MTZ_CMD_SETUP_MEAS);
wire cancel_ok = trig_src_q == `MTZ_SRC_BUS || trig_src_q == `MTZ_SRC_HOLD;
wire is_arm = cmd_go && (cmd_code == `MTZ_CMD_ARM || cmd_code == `MTZ_CMD_READ ||
    cmd_code == `MTZ_CMD_SETUP_MEAS);
wire sw_trig = cmd_go && cmd_code == `MTZ_CMD_SW_TRIG;
wire bus_trig = cmd_go && cmd_code == `MTZ_CMD_BUS_TRIG;
wire trig_hit = state_q == ST_WAIT && (trig_src_q == `MTZ_SRC_IMM ||
    (trig_src_q == `MTZ_SRC_HOLD && sw_trig) || (trig_src_q == `MTZ_SRC_BUS && (bus_trig || sw_trig)));
wire trig_ign = state_q != ST_WAIT && (sw_trig || bus_trig);
wire az_allowed = !aper_10us_q;
wire delay_done = delay_cnt_q == 32'h0000_0000;

always @(posedge ref_clk or negedge nrst)
begin
    if (!nrst)
    begin
        trig_src_q <= `MTZ_SRC_IMM;
        trig_count_q <= 8'h01;
        trig_count_auto_q <= 1'b1;
        trig_delay_auto_q <= 1'b1;
        sample_count_q <= 8'h01;
        samp_src_imm_q <= 1'b1;
        ocomp_q <= 1'b0;
        azero_q <= `MTZ_AZ_ON;
        func_q <= 2'h0;
        range_q <= 3'h0;
        autorange_q <= 1'b1;
        integration_line_cycles_q <= 4'h1;
        aper_10us_q <= 1'b0;
        err_q <= `MTZ_ERR_NONE;
        lf_query_q <= `MTZ_LF_RESET;
    end
    else
    begin
        if (is_setup)
        begin
            // Loads configuration; MTZ_CMD_SETUP_MEAS also arms, otherwise acquisition waits for arm or read
            func_q <= w_q[13:12];
            autorange_q <= w_q[14];
            range_q <= w_q[26:24];
            integration_line_cycles_q <= 4'h1;
            aper_10us_q <= 1'b0;
            azero_q <= `MTZ_AZ_ON;
            trig_src_q <= `MTZ_SRC_IMM;
            trig_count_auto_q <= 1'b1;
            trig_delay_auto_q <= 1'b1;
            trig_count_q <= 8'h01;
            sample_count_q <= 8'h01;
            samp_src_imm_q <= 1'b1;
            ocomp_q <= 1'b0;
        end
        else if (is_reset)
            azero_q <= `MTZ_AZ_ON;
        else if (cmd_go && cmd_code == `MTZ_CMD_AZERO)
        begin
            if (cmd_arg == 8'h00 || cmd_arg == 8'h01 || cmd_arg == 8'h02)
                azero_q <= cmd_arg[1:0];
            else
                err_q <= `MTZ_ERR_PARAM;
        end
        if (cmd_go && cmd_code == `MTZ_CMD_LFREQ && !lf_ok)
            err_q <= `MTZ_ERR_PARAM;
        if (cmd_go && cmd_code == `MTZ_CMD_LFREQ_Q)
            lf_query_q <= cmd_kw == `MTZ_KW_VALUE ? lfreq_q : lf_val;
        if (cfg_wr)
        begin
            trig_src_q <= w_q[1:0];
            trig_count_q <= w_q[15:8];
            trig_count_auto_q <= 1'b0;
        end
        if (setup_wr)
        begin
            range_q <= w_q[6:4];
            autorange_q <= w_q[3];
            integration_line_cycles_q <= w_q[10:7];
            aper_10us_q <= w_q[11];
        end
        if (is_cancel && !cancel_ok)
            err_q <= `MTZ_ERR_CANCEL;
        if (trig_ign)
            err_q <= `MTZ_ERR_TRIG_IGN;
        if (wr_go && wr_idx == 4'h6)
            err_q <= `MTZ_ERR_NONE;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Trigger and conversion sequencer

always @(posedge ref_clk or negedge nrst)
begin
    if (!nrst)
    begin
        state_q <= ST_IDLE;
        conv_start_q <= 1'b0;
        conv_zero_q <= 1'b0;
        conv_input_en_q <= 1'b1;
        subtract_zero_q <= 1'b0;
        zero_valid_q <= 1'b0;
        delay_cnt_q <= 32'h0000_0000;
        trig_left_q <= 8'h00;
        conv_busy_q <= 1'b0;
    end
    else
    begin
        conv_start_q <= 1'b0;
        // One conversion in flight; a second start would restart the converter
        if (conv_start_q)
            conv_busy_q <= 1'b1;
        else if (conv_done)
            conv_busy_q <= 1'b0;
        // Function change invalidates the held zero; range change does not
        if (is_setup && w_q[13:12] != func_q)
            zero_valid_q <= 1'b0;
        if (is_reset || (is_cancel && cancel_ok))
        begin
            // Other trigger settings are left as they were
            state_q <= ST_IDLE;
            conv_zero_q <= 1'b0;
            conv_input_en_q <= 1'b1;
        end
        else
        begin
            case (state_q)
                ST_IDLE:
                    if (is_arm)
                    begin
                        state_q <= ST_WAIT;
                        trig_left_q <= trig_count_q;
                    end
                ST_WAIT:
                    if (trig_hit)
                    begin
                        delay_cnt_q <= (trig_delay_auto_q && func_q == 2'h1) ? AC_DLY : 32'h0000_0000;
                        conv_zero_q <= 1'b0;
                        conv_input_en_q <= 1'b1;
                        state_q <= ST_MEAS;
                    end
                ST_MEAS:
                    if (!delay_done)
                        delay_cnt_q <= delay_cnt_q - 32'h0000_0001;
                    else if (conv_busy_q && conv_done)
                    begin
                        if (az_allowed && (azero_q == `MTZ_AZ_ON || !zero_valid_q))
                        begin
                            state_q <= ST_ZERO;
                            conv_zero_q <= 1'b1;
                            conv_input_en_q <= 1'b0;
                            conv_start_q <= 1'b1;
                        end
                        else
                        begin
                            subtract_zero_q <= zero_valid_q;
                            trig_left_q <= trig_left_q - 8'h01;
                            state_q <= (trig_left_q == 8'h01) ? ST_IDLE : ST_WAIT;
                        end
                    end
                    else if (conv_input_en_q && !conv_zero_q && !conv_start_q && !conv_busy_q)
                        conv_start_q <= 1'b1;
                ST_ZERO:
                    if (conv_busy_q && conv_done)
                    begin
                        zero_valid_q <= 1'b1;
                        subtract_zero_q <= 1'b1;
                        conv_zero_q <= 1'b0;
                        conv_input_en_q <= 1'b1;
                        trig_left_q <= trig_left_q - 8'h01;
                        state_q <= (trig_left_q == 8'h01) ? ST_IDLE : ST_WAIT;
                    end
                default:
                    state_q <= ST_IDLE;
            endcase
        end
    end
end

endmodule

// file: tb/mtz_control_assertions.sv
`timescale 1ns/1ns
module mtz_control_chk #(
    parameter AC_DELAY_CYC = 20
)(
    // Clock and reset
    input wire ref_clk,
    input wire nrst,
    // Bus handshakes
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [1:0] s_axi_rresp,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    // Converter side
    input wire conv_done,
    input wire conv_start_q,
    input wire conv_zero_q,
    input wire conv_input_en_q,
    input wire subtract_zero_q
);
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (!nrst);
    ////////////////////////////////////////
    a_reset_quiet: assert property ($rose(nrst) |-> conv_input_en_q && !conv_zero_q
        && !s_axi_bvalid && !s_axi_rvalid) else $error("outputs not at reset values");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
        && $stable(s_axi_bresp)) else $error("write response dropped early");
    a_rresp_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
        && $stable(s_axi_rresp)) else $error("read response dropped early");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write not answered");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered");
    a_read_decerr: assert property (s_axi_arvalid && s_axi_arready && (s_axi_araddr > 8'h18
        || s_axi_araddr[1:0] != 2'b00) |=> s_axi_rresp == 2'b11) else $error("no decode error");
    a_start_pulse: assert property (conv_start_q |=> !conv_start_q)
        else $error("start longer than one cycle");
    a_zero_input_off: assert property (conv_zero_q |-> !conv_input_en_q)
        else $error("input connected during zero");
    a_zero_subtract: assert property (conv_zero_q && conv_done |-> ##[1:3] subtract_zero_q)
        else $error("zero not subtracted");
endmodule

bind mtz_control mtz_control_chk #(.AC_DELAY_CYC(AC_DELAY_CYC)) u_mtz_control_chk (.*);

// file: tb/mtz_conv_model.sv
`timescale 1ns/1ns
module mtz_conv_model (
    // Clock and reset
    input wire ref_clk,
    input wire nrst,
    // Conversion handshake
    input wire start,
    input wire slow,
    output reg done_q
);
    reg [3:0] cnt_q;
    // Slow mode stretches a conversion so the block has to wait
    always @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            cnt_q <= 4'h0;
            done_q <= 1'b0;
        end
        else
        begin
            done_q <= cnt_q == 4'h1;
            if (start)
                cnt_q <= slow ? 4'h9 : 4'h2;
            else if (cnt_q != 4'h0)
                cnt_q <= cnt_q - 4'h1;
        end
    end
endmodule

// file: tb/tb.sv
`timescale 1ns/1ns
`include "mtz_consts.vh"
module tb;
    reg ref_clk = 1'b0;
    reg nrst = 1'b0;
    reg [7:0] s_axi_awaddr = 8'h00;
    reg s_axi_awvalid = 1'b0;
    reg [31:0] s_axi_wdata = 32'h0;
    reg [3:0] s_axi_wstrb = 4'hf;
    reg s_axi_wvalid = 1'b0;
    reg s_axi_bready = 1'b0;
    reg [7:0] s_axi_araddr = 8'h00;
    reg s_axi_arvalid = 1'b0;
    reg s_axi_rready = 1'b0;
    reg slow = 1'b0;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire conv_done, conv_start_q, conv_zero_q, conv_input_en_q, subtract_zero_q;
    integer seed = 93789;
    integer fail_count = 0;
    integer checks_done = 0;
    integer cycles = 0;
    integer i;
    reg [65:0] e;
    reg [65:0] rd_q[$];
    reg [1:0] b_q[$];

    always #5 ref_clk = ~ref_clk;

    mtz_control #(.AC_DELAY_CYC(20)) u_mtz_control (.*);
    mtz_conv_model u_mtz_conv_model (.ref_clk(ref_clk), .nrst(nrst), .start(conv_start_q),
        .slow(slow), .done_q(conv_done));
    ////////////////////////////////////////
    function automatic logic rbit();
        rbit = ($random(seed) % 2) != 0;
    endfunction

    task chk(input string nm, input [33:0] seen, input [33:0] exp);
    begin
        checks_done = checks_done + 1;
        if (seen !== exp)
        begin
            fail_count = fail_count + 1;
            $display("[ERR] %0s exp %h seen %h", nm, exp, seen);
        end
    end
    endtask

    task final_report;
    begin
        if (fail_count == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    end
    endtask

    // Ready is raised after a random pause to exercise held responses
    task wr(input [7:0] a, input [31:0] d, input [1:0] r);
    begin
        b_q.push_back(r);
        @(posedge ref_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do
        begin
            @(posedge ref_clk);
            if (s_axi_awvalid && s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
                s_axi_wvalid <= 1'b0;
            if (!s_axi_bready)
                s_axi_bready <= rbit();
        end
        while (!(s_axi_bvalid && s_axi_bready));
        s_axi_bready <= 1'b0;
    end
    endtask

    task rd(input [7:0] a, input [31:0] m, input [31:0] x, input [1:0] r);
    begin
        rd_q.push_back({r, m, x});
        @(posedge ref_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do
        begin
            @(posedge ref_clk);
            if (s_axi_arvalid && s_axi_arready)
                s_axi_arvalid <= 1'b0;
            if (!s_axi_rready)
                s_axi_rready <= rbit();
        end
        while (!(s_axi_rvalid && s_axi_rready));
        s_axi_rready <= 1'b0;
    end
    endtask

    task cmd(input [3:0] c, input [1:0] k, input [7:0] g);
        wr(`MTZ_REG_CMD, {8'h00, g, 6'h00, k, 4'h0, c}, 2'b00);
    endtask
    ////////////////////////////////////////
    always @(posedge ref_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            fail_count = fail_count + 1;
            final_report;
        end
        if (s_axi_rvalid && s_axi_rready)
        begin
            e = rd_q.pop_front();
            chk("rdata", {s_axi_rresp, s_axi_rdata & e[63:32]}, {e[65:64], e[31:0]});
        end
        if (s_axi_bvalid && s_axi_bready)
            chk("bresp", {32'h0, s_axi_bresp}, {32'h0, b_q.pop_front()});
    end

    initial
    begin
        repeat (12) @(posedge ref_clk);
        nrst <= 1'b1;
        rd(`MTZ_REG_LFREQ, 32'hff, 32'h3c, 2'b00);
        rd(`MTZ_REG_AZERO, 32'h1, 32'h1, 2'b00);
        rd(`MTZ_REG_STATUS, 32'h60, 32'h20, 2'b00);
        rd(`MTZ_REG_CMD, 32'hffffffff, 32'h0, 2'b00);
        cmd(`MTZ_CMD_LFREQ, `MTZ_KW_VALUE, 8'h32);
        rd(`MTZ_REG_LFREQ, 32'hff, 32'h32, 2'b00);
        cmd(`MTZ_CMD_LFREQ, `MTZ_KW_MAX, 8'h00);
        rd(`MTZ_REG_LFREQ, 32'hff, 32'h3c, 2'b00);
        cmd(`MTZ_CMD_LFREQ, `MTZ_KW_MIN, 8'h00);
        rd(`MTZ_REG_LFREQ, 32'hff, 32'h32, 2'b00);
        wr(`MTZ_REG_ERROR, 32'h0, 2'b00);
        cmd(`MTZ_CMD_LFREQ, `MTZ_KW_VALUE, {4'h4, 4'($random(seed))});
        rd(`MTZ_REG_ERROR, 32'hff, 32'h03, 2'b00);
        rd(`MTZ_REG_LFREQ, 32'hff, 32'h32, 2'b00);
        cmd(`MTZ_CMD_LFREQ_Q, `MTZ_KW_MAX, 8'h00);
        rd(`MTZ_REG_LFREQ, 32'hff00, 32'h3c00, 2'b00);
        cmd(`MTZ_CMD_LFREQ_Q, `MTZ_KW_VALUE, 8'h00);
        rd(`MTZ_REG_LFREQ, 32'hff00, 32'h3200, 2'b00);
        cmd(`MTZ_CMD_LFREQ, `MTZ_KW_VALUE, 8'h3c);
        cmd(`MTZ_CMD_LFREQ_Q, `MTZ_KW_MIN, 8'h00);
        rd(`MTZ_REG_LFREQ, 32'hff00, 32'h3200, 2'b00);
        cmd(`MTZ_CMD_LFREQ, `MTZ_KW_VALUE, 8'h32);
        cmd(`MTZ_CMD_RESET, `MTZ_KW_VALUE, 8'h00);
        rd(`MTZ_REG_LFREQ, 32'hff, 32'h32, 2'b00);
        for (i = 0; i < 3; i = i + 1)
        begin
            cmd(`MTZ_CMD_AZERO, `MTZ_KW_VALUE, i[7:0]);
            rd(`MTZ_REG_AZERO, 32'h7, {29'h0, i[1:0], i == 1}, 2'b00);
        end
        cmd(`MTZ_CMD_RESET, `MTZ_KW_VALUE, 8'h00);
        rd(`MTZ_REG_AZERO, 32'h1, 32'h1, 2'b00);
        for (i = 1; i < 3; i = i + 1)
        begin
            wr(`MTZ_REG_CONFIG, {16'h0, 8'h05, 6'h0, i[1:0]}, 2'b00);
            cmd(`MTZ_CMD_ARM, `MTZ_KW_VALUE, 8'h00);
            rd(`MTZ_REG_STATUS, 32'h60, 32'h40, 2'b00);
            cmd(`MTZ_CMD_CANCEL, `MTZ_KW_VALUE, 8'h00);
            rd(`MTZ_REG_STATUS, 32'h60, 32'h20, 2'b00);
            wr(`MTZ_REG_ERROR, 32'h0, 2'b00);
            cmd(i == 1 ? `MTZ_CMD_BUS_TRIG : `MTZ_CMD_SW_TRIG, `MTZ_KW_VALUE, 8'h00);
            rd(`MTZ_REG_ERROR, 32'hff, 32'h01, 2'b00);
            rd(`MTZ_REG_CONFIG, 32'hffff, {16'h0, 8'h05, 6'h0, i[1:0]}, 2'b00);
            cmd(`MTZ_CMD_ARM, `MTZ_KW_VALUE, 8'h00);
            rd(`MTZ_REG_STATUS, 32'h60, 32'h40, 2'b00);
            cmd(`MTZ_CMD_RESET, `MTZ_KW_VALUE, 8'h00);
            rd(`MTZ_REG_STATUS, 32'h60, 32'h20, 2'b00);
        end
        wr(`MTZ_REG_CONFIG, 32'h0503, 2'b00);
        cmd(`MTZ_CMD_ARM, `MTZ_KW_VALUE, 8'h00);
        wr(`MTZ_REG_ERROR, 32'h0, 2'b00);
        cmd(`MTZ_CMD_CANCEL, `MTZ_KW_VALUE, 8'h00);
        rd(`MTZ_REG_ERROR, 32'hff, 32'h02, 2'b00);
        rd(`MTZ_REG_STATUS, 32'h60, 32'h40, 2'b00);
        cmd(`MTZ_CMD_RESET, `MTZ_KW_VALUE, 8'h00);
        cmd(`MTZ_CMD_AZERO, `MTZ_KW_VALUE, 8'h00);
        cmd(`MTZ_CMD_SETUP, `MTZ_KW_VALUE, 8'h00);
        rd(`MTZ_REG_STATUS, 32'h3e, 32'h36, 2'b00);
        rd(`MTZ_REG_CONFIG, 32'h3, 32'h0, 2'b00);
        rd(`MTZ_REG_SETUP, 32'h7e0, 32'h040, 2'b00);
        rd(`MTZ_REG_AZERO, 32'h1, 32'h1, 2'b00);
        slow <= rbit();
        cmd(`MTZ_CMD_ARM, `MTZ_KW_VALUE, 8'h00);
        repeat (60) @(posedge ref_clk);
        rd(`MTZ_REG_STATUS, 32'h80, 32'h80, 2'b00);
        wr(`MTZ_REG_SETUP, 32'h50, 2'b00);
        rd(`MTZ_REG_SETUP, 32'h3c, 32'h14, 2'b00);
        rd(`MTZ_REG_STATUS, 32'h80, 32'h80, 2'b00);
        cmd(`MTZ_CMD_AZERO, `MTZ_KW_VALUE, 8'h00);
        cmd(`MTZ_CMD_SETUP_MEAS, `MTZ_KW_VALUE, 8'h00);
        rd(`MTZ_REG_AZERO, 32'h1, 32'h1, 2'b00);
        repeat (60) @(posedge ref_clk);
        rd(8'h1c, 32'h0, 32'h0, 2'b11);
        wr(8'h20, 32'h0, 2'b11);
        final_report;
    end
endmodule
